// ### bench/ir_front_model.sv
// Behavioural model of the receiver front end that drives the serial pin.
`timescale 1ns/10ps
module ir_front_model (
   input wire logic clk_sys,
   output logic serial_input_pin
);
   int unsigned tick_clks = 64;
   logic invert = 1'b0;
   initial serial_input_pin = 1'b0;
   // Holds a level for a whole number of source ticks.
   task automatic hold(input logic lvl, input int unsigned n);
      @(posedge clk_sys);
      serial_input_pin <= lvl ^ invert;
      repeat (n * tick_clks - 1) @(posedge clk_sys);
   endtask
   // Sends a guide, then the bits LSB first, then a trailing low.
   task automatic frame(input int nbits, input logic [15:0] data, input int unsigned tail);
      hold(1'b1, 14);
      hold(1'b0, 5);
      for (int i = 0; i < nbits; i++) begin
         hold(1'b1, data[i] ? 9 : 4);
         hold(1'b0, 5);
      end
      hold(1'b0, tail);
   endtask
endmodule

// ### bench/remote_pulse_width_receiver_bench.sv
// Self-checking bench for the remote pulse-width receiver.
`timescale 1ns/10ps
module remote_pulse_width_receiver_bench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sub_clk = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic pin;
   int err_count = 0;
   int n_checks = 0;
   logic [7:0] lim [9] = '{8'h08, 8'h14, 8'h03, 8'h08, 8'h02, 8'h06, 8'h06, 8'h0c, 8'h04};
   int unsigned wav [4][6] = '{'{14, 2, 4, 2, 4, 30}, '{14, 5, 9, 5, 14, 30},
      '{14, 10, 2, 30, 0, 0}, '{4, 2, 4, 30, 0, 0}};
   logic [7:0] est [4] = '{8'h03, 8'h03, 8'h03, 8'h00};
   // The system clock, and a subsystem clock of about 100 system clocks.
   always #25 clk_sys = ~clk_sys;
   always #2490 sub_clk <= ~sub_clk;
   remote_pulse_width_receiver dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .serial_input_pin(pin), .sub_clk(sub_clk), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .guide_detect_event(), .error_event(),
      .end_of_frame_event(), .byte_full_event());
   ir_front_model fe (.clk_sys(clk_sys), .serial_input_pin(pin));
   task automatic give_verdict();
      if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // Reads one register; its data stand only in the cycle after the strobe.
   task automatic ck(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 cmp(what, exp, rdata);
   endtask
   // Settings change only while reception is off, bits 2 and 3 kept zero.
   task automatic cfg(input logic [7:0] ctl, input int unsigned tick);
      wreg(rpw_pkg::ADDR_CONTROL, 8'h00);
      for (int i = 0; i < rpw_pkg::LIM_COUNT; i++) wreg(rpw_pkg::ADDR_LIMIT_BASE + 4'(i), lim[i]);
      wreg(rpw_pkg::ADDR_CONTROL, ctl & 8'h73);
      wreg(rpw_pkg::ADDR_CONTROL, (ctl & 8'h73) | 8'h80);
      wreg(rpw_pkg::ADDR_STATUS_CLEAR, 8'h0f);
      fe.tick_clks = tick;
   endtask
   task automatic t_regs();
      ck("control", rpw_pkg::ADDR_CONTROL, rpw_pkg::CTL_RESET);
      ck("status", rpw_pkg::ADDR_STATUS, 8'h00);
      ck("unmapped", 4'hf, 8'h00);
      cfg(8'h13, 64);
      ck("control", rpw_pkg::ADDR_CONTROL, 8'h93);
      ck("limit", rpw_pkg::ADDR_LIMIT_BASE + 4'h1, 8'h14);
   endtask
   // Eleven bits: one full byte, three left over, then a frame while halted.
   task automatic t_frame();
      cfg(8'h00, 64);
      fe.frame(11, 16'h05a5, 30);
      ck("status", rpw_pkg::ADDR_STATUS, 8'h0e);
      ck("buffer", rpw_pkg::ADDR_DATA_BUFFER, 8'ha5);
      wreg(rpw_pkg::ADDR_STATUS_CLEAR, 8'h0f);
      fe.frame(0, 16'h0000, 30);
      ck("status", rpw_pkg::ADDR_STATUS, 8'h00);
      ck("count", rpw_pkg::ADDR_SHIFT_COUNT, 8'h03);
      ck("shift", rpw_pkg::ADDR_SHIFT_REG, 8'ha0);
      ck("count", rpw_pkg::ADDR_SHIFT_COUNT, 8'h00);
      wreg(rpw_pkg::ADDR_CONTROL, 8'h00);
      ck("buffer", rpw_pkg::ADDR_DATA_BUFFER, 8'h00);
   endtask
   // Every source select, and the prescaler, with the tick rate to match.
   task automatic t_sweep();
      logic [7:0] sel [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20};
      int unsigned tk [5] = '{64, 128, 256, 100, 128};
      for (int i = 0; i < 5; i++) begin
         cfg(sel[i], tk[i]);
         fe.frame(0, 16'h0000, 30);
         ck("status", rpw_pkg::ADDR_STATUS, 8'h06);
         ck("shift", rpw_pkg::ADDR_SHIFT_REG, 8'h00);
      end
   endtask
   // A two-tick dip in the guide passes the short filter only.
   task automatic t_noise();
      for (int nw = 0; nw < 2; nw++) begin
         cfg(nw ? 8'h40 : 8'h00, 64);
         fe.hold(1'b1, 7);
         fe.hold(1'b0, 2);
         fe.hold(1'b1, 7);
         fe.hold(1'b0, 30);
         ck("status", rpw_pkg::ADDR_STATUS, nw ? 8'h06 : 8'h00);
      end
   endtask
   // Short low, long high, early end rise, and a short guide.
   task automatic t_errors();
      for (int i = 0; i < 4; i++) begin
         cfg(8'h00, 64);
         for (int j = 0; j < 6; j++) if (wav[i][j] != 0) fe.hold(!j[0], wav[i][j]);
         ck("status", rpw_pkg::ADDR_STATUS, est[i]);
         ck("count", rpw_pkg::ADDR_SHIFT_COUNT, 8'h00);
      end
   endtask
   task automatic t_invert();
      fe.invert = 1'b1;
      fe.hold(1'b0, 2);
      cfg(8'h10, 64);
      fe.frame(0, 16'h0000, 30);
      ck("status", rpw_pkg::ADDR_STATUS, 8'h06);
      wreg(rpw_pkg::ADDR_CONTROL, 8'h00);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_frame();
      t_sweep();
      t_noise();
      t_errors();
      t_invert();
      give_verdict();
   end
   // Cuts a hang short.
   initial begin
      repeat (99000) @(posedge clk_sys);
      err_count++;
      give_verdict();
   end
endmodule

// ### bench/rpw_port_sva.sv
// Port checker for the remote pulse-width receiver.
`timescale 1ns/10ps
module rpw_port_sva (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic guide_detect_event,
   input wire logic error_event,
   input wire logic end_of_frame_event,
   input wire logic byte_full_event
);
   logic en_q;
   logic armed_q;
   logic halt_q;
   wire off = !rst_n || (wr && addr == rpw_pkg::ADDR_CONTROL && !wdata[7]);
   wire any_ev = guide_detect_event || error_event || end_of_frame_event || byte_full_event;
   // Follows the enable bit as software writes it.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) en_q <= 1'b0;
      else if (wr && addr == rpw_pkg::ADDR_CONTROL) en_q <= wdata[7];
   end
   // A guide allows one error; the error or a disable uses it up.
   always_ff @(posedge clk_sys) begin
      if (off || error_event) armed_q <= 1'b0;
      else if (guide_detect_event) armed_q <= 1'b1;
   end
   // An end of frame halts reception until the shift register is read.
   always_ff @(posedge clk_sys) begin
      if (off || (rd && addr == rpw_pkg::ADDR_SHIFT_REG)) halt_q <= 1'b0;
      else if (end_of_frame_event) halt_q <= 1'b1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Reading the shift register and then the bit counter.
   sequence s_read_pair;
      rd && addr == rpw_pkg::ADDR_SHIFT_REG ##2 rd && addr == rpw_pkg::ADDR_SHIFT_COUNT;
   endsequence
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata not zero");
   a_guide_pulse: assert property (guide_detect_event |=> !guide_detect_event)
      else $error("guide event longer than one cycle");
   a_error_pulse: assert property (error_event |=> !error_event)
      else $error("error event longer than one cycle");
   a_end_pulse: assert property (end_of_frame_event |=> !end_of_frame_event)
      else $error("end event longer than one cycle");
   a_error_armed: assert property (error_event |-> armed_q)
      else $error("error without a fresh guide");
   a_full_framed: assert property (byte_full_event |-> armed_q)
      else $error("byte full outside a frame");
   a_end_framed: assert property (end_of_frame_event |-> armed_q && !halt_q)
      else $error("end event outside a frame");
   a_halt_blocks: assert property (halt_q |-> !guide_detect_event)
      else $error("guide while halted");
   a_off_quiet: assert property (!en_q |-> !any_ev)
      else $error("event while disabled");
   a_read_clears: assert property (s_read_pair |=> rdata == 8'h00)
      else $error("bit counter not cleared by shift read");
endmodule
bind remote_pulse_width_receiver rpw_port_sva chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .guide_detect_event(guide_detect_event), .error_event(error_event),
   .end_of_frame_event(end_of_frame_event), .byte_full_event(byte_full_event));

// ### verilog/remote_pulse_width_receiver.sv
// Remote pulse-width receiver with guide pulse, noise filter and byte buffer.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module remote_pulse_width_receiver #(
   parameter int DATA_W = 8,
   parameter int CNT_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic serial_input_pin,
   input wire logic sub_clk,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic guide_detect_event,
   output logic error_event,
   output logic end_of_frame_event,
   output logic byte_full_event
);
   logic [7:0] control_q;
   logic [7:0] status_q;
   logic [7:0] rdata_q;
   logic [CNT_W-1:0] limit_q [rpw_pkg::LIM_COUNT];
   logic [7:0] div_q;
   logic [2:0] sub_q;
   logic half_q;
   logic src_tick;
   logic op_tick;
   logic sync_q, first_sample_q, second_sample_q, third_sample_q, filt_prev_q;
   logic filt;
   logic rise;
   logic fall;
   rpw_pkg::rx_state_t state_q;
   logic [CNT_W-1:0] width_q;
   logic [DATA_W-1:0] shift_q;
   logic [3:0] bit_count_q;
   logic [DATA_W-1:0] buffer_q;
   logic err_armed_q;
   logic guide_ev_q, err_ev_q, end_ev_q, full_ev_q;
   logic enable;
   logic shift_read;
   logic do_error;
   logic do_shift;
   logic shift_bit;

   // True when the width lies in [lo, hi).
   function automatic logic in_range(input logic [CNT_W-1:0] w, input logic [CNT_W-1:0] lo,
                                     input logic [CNT_W-1:0] hi);
      in_range = (w >= lo) && (w < hi);
   endfunction

   assign enable = control_q[rpw_pkg::CTL_ENABLE];
   assign shift_read = rd && (addr == rpw_pkg::ADDR_SHIFT_REG);

   // Control register; reserved bits 2 and 3 are forced to zero.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         control_q <= rpw_pkg::CTL_RESET;
      end else if (wr && addr == rpw_pkg::ADDR_CONTROL) begin
         control_q <= wdata & rpw_pkg::CTL_WRITE_MASK;
      end
   end

   // Limit registers; software only changes them while disabled.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < rpw_pkg::LIM_COUNT; i++) begin
            limit_q[i] <= '0;
         end
      end else if (wr && addr >= rpw_pkg::ADDR_LIMIT_BASE &&
                   addr < rpw_pkg::ADDR_LIMIT_BASE + 4'(rpw_pkg::LIM_COUNT)) begin
         limit_q[addr - rpw_pkg::ADDR_LIMIT_BASE] <= wdata[CNT_W-1:0];
      end
   end

   // Peripheral divider and subclock edge detector give the source tick.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_q <= 8'h00;
         sub_q <= 3'h0;
      end else begin
         div_q <= div_q + 8'h01;
         sub_q <= {sub_q[1:0], sub_clk};
      end
   end

   // Source clock select.
   always_comb begin
      case ({control_q[rpw_pkg::CTL_SEL_HI], control_q[rpw_pkg::CTL_SEL_LO]})
         2'b00: src_tick = (div_q & rpw_pkg::DIV64_MASK) == rpw_pkg::DIV64_MASK;
         2'b01: src_tick = (div_q & rpw_pkg::DIV128_MASK) == rpw_pkg::DIV128_MASK;
         2'b10: src_tick = div_q == rpw_pkg::DIV256_MASK;
         default: src_tick = sub_q[1] && !sub_q[2];
      endcase
   end

   // Optional halving of the source tick into the operating tick.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !enable) begin
         half_q <= 1'b0;
      end else if (src_tick) begin
         half_q <= !half_q;
      end
   end
   assign op_tick = src_tick && (!control_q[rpw_pkg::CTL_PRESCALE] || half_q);

   // Noise filter on the operating tick: sync, then confirming samples.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !enable) begin
         sync_q <= 1'b0;
         first_sample_q <= 1'b0;
         second_sample_q <= 1'b0;
         third_sample_q <= 1'b0;
         filt_prev_q <= 1'b0;
      end else if (op_tick) begin
         sync_q <= serial_input_pin ^ control_q[rpw_pkg::CTL_INVERT];
         first_sample_q <= sync_q;
         if (sync_q == first_sample_q) begin
            second_sample_q <= first_sample_q;
         end
         if (sync_q == second_sample_q) begin
            third_sample_q <= second_sample_q;
         end
         filt_prev_q <= filt;
      end
   end
   assign filt = control_q[rpw_pkg::CTL_NOISE_WIDTH] ? third_sample_q : second_sample_q;
   assign rise = op_tick && filt && !filt_prev_q;
   assign fall = op_tick && !filt && filt_prev_q;

   // Error decision per state; suppressed until a guide has been seen.
   always_comb begin
      do_error = 1'b0;
      do_shift = 1'b0;
      shift_bit = 1'b0;
      case (state_q)
         rpw_pkg::DATA_LOW: begin
            do_error = rise && width_q < limit_q[rpw_pkg::LIM_LOW_SHORT];
         end
         rpw_pkg::DATA_HIGH: begin
            if (fall) begin
               if (in_range(width_q, limit_q[rpw_pkg::LIM_ZERO_SHORT],
                            limit_q[rpw_pkg::LIM_ZERO_LONG])) begin
                  do_shift = 1'b1;
               end else if (in_range(width_q, limit_q[rpw_pkg::LIM_ONE_SHORT],
                                     limit_q[rpw_pkg::LIM_ONE_LONG])) begin
                  do_shift = 1'b1;
                  shift_bit = 1'b1;
               end else begin
                  do_error = 1'b1;
               end
            end else if (op_tick && filt && width_q >= limit_q[rpw_pkg::LIM_ONE_LONG]) begin
               do_error = 1'b1;
            end
         end
         rpw_pkg::END_WIDTH: begin
            do_error = rise && width_q < limit_q[rpw_pkg::LIM_END_WIDTH];
         end
         default: begin
            do_error = 1'b0;
         end
      endcase
   end

   // Measurement state machine and width counter.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !enable) begin
         state_q <= rpw_pkg::WAIT_RISE;
         width_q <= '0;
      end else begin
         if (op_tick && width_q != '1) begin
            width_q <= width_q + 1'b1;
         end
         case (state_q)
            rpw_pkg::WAIT_RISE: begin
               if (rise) begin
                  state_q <= rpw_pkg::GUIDE_HIGH;
                  width_q <= '0;
               end
            end
            rpw_pkg::GUIDE_HIGH: begin
               if (fall) begin
                  width_q <= '0;
                  if (in_range(width_q, limit_q[rpw_pkg::LIM_GUIDE_SHORT],
                               limit_q[rpw_pkg::LIM_GUIDE_LONG])) begin
                     state_q <= rpw_pkg::DATA_LOW;
                  end else begin
                     state_q <= rpw_pkg::WAIT_RISE;
                  end
               end
            end
            rpw_pkg::DATA_LOW: begin
               if (rise) begin
                  width_q <= '0;
                  state_q <= do_error ? rpw_pkg::GUIDE_HIGH : rpw_pkg::DATA_HIGH;
               end else if (op_tick && width_q >= limit_q[rpw_pkg::LIM_LOW_LONG]) begin
                  width_q <= '0;
                  state_q <= rpw_pkg::END_WIDTH;
               end
            end
            rpw_pkg::DATA_HIGH: begin
               if (do_shift) begin
                  width_q <= '0;
                  state_q <= rpw_pkg::DATA_LOW;
               end else if (do_error) begin
                  state_q <= rpw_pkg::WAIT_RISE;
               end
            end
            rpw_pkg::END_WIDTH: begin
               if (rise) begin
                  width_q <= '0;
                  state_q <= rpw_pkg::GUIDE_HIGH;
               end else if (op_tick && width_q >= limit_q[rpw_pkg::LIM_END_WIDTH]) begin
                  state_q <= rpw_pkg::HALTED;
               end
            end
            rpw_pkg::HALTED: begin
               if (shift_read) begin
                  state_q <= rpw_pkg::WAIT_RISE;
               end
            end
            default: begin
               state_q <= rpw_pkg::WAIT_RISE;
            end
         endcase
      end
   end

   // Error arming: set by a guide, spent by one error.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !enable) begin
         err_armed_q <= 1'b0;
      end else if (state_q == rpw_pkg::GUIDE_HIGH && fall && in_range(width_q,
                   limit_q[rpw_pkg::LIM_GUIDE_SHORT], limit_q[rpw_pkg::LIM_GUIDE_LONG])) begin
         err_armed_q <= 1'b1;
      end else if (do_error) begin
         err_armed_q <= 1'b0;
      end
   end

   // Event pulses, one cycle each.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !enable) begin
         guide_ev_q <= 1'b0;
         err_ev_q <= 1'b0;
         end_ev_q <= 1'b0;
         full_ev_q <= 1'b0;
      end else begin
         guide_ev_q <= state_q == rpw_pkg::GUIDE_HIGH && fall && in_range(width_q,
                       limit_q[rpw_pkg::LIM_GUIDE_SHORT], limit_q[rpw_pkg::LIM_GUIDE_LONG]);
         err_ev_q <= do_error && err_armed_q;
         end_ev_q <= state_q == rpw_pkg::END_WIDTH && !rise && op_tick &&
                     width_q >= limit_q[rpw_pkg::LIM_END_WIDTH];
         full_ev_q <= do_shift && bit_count_q == 4'(DATA_W - 1);
      end
   end

   // Shift register, bit counter and data buffer.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !enable) begin
         shift_q <= '0;
         bit_count_q <= 4'h0;
         buffer_q <= '0;
      end else if (do_error) begin
         shift_q <= '0;
         bit_count_q <= 4'h0;
      end else if (do_shift) begin
         if (bit_count_q == 4'(DATA_W - 1)) begin
            buffer_q <= {shift_bit, shift_q[DATA_W-1:1]};
            shift_q <= '0;
            bit_count_q <= 4'h0;
         end else begin
            shift_q <= {shift_bit, shift_q[DATA_W-1:1]};
            bit_count_q <= bit_count_q + 4'h1;
         end
      end else if (shift_read) begin
         shift_q <= '0;
         bit_count_q <= 4'h0;
      end
   end

   // Sticky status bits; a new event wins over a write-one clear.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status_q <= 8'h00;
      end else begin
         status_q <= (status_q & ~((wr && addr == rpw_pkg::ADDR_STATUS_CLEAR) ? wdata : 8'h00))
                     | {4'h0, full_ev_q, end_ev_q, guide_ev_q, err_ev_q};
      end
   end

   // Read data, valid in the cycle after the read strobe only.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !rd) begin
         rdata_q <= 8'h00;
      end else begin
         case (addr)
            rpw_pkg::ADDR_CONTROL: rdata_q <= control_q;
            rpw_pkg::ADDR_STATUS: rdata_q <= status_q;
            rpw_pkg::ADDR_DATA_BUFFER: rdata_q <= 8'(buffer_q);
            rpw_pkg::ADDR_SHIFT_REG: rdata_q <= 8'(shift_q);
            rpw_pkg::ADDR_SHIFT_COUNT: rdata_q <= {4'h0, bit_count_q};
            default: begin
               if (addr >= rpw_pkg::ADDR_LIMIT_BASE &&
                   addr < rpw_pkg::ADDR_LIMIT_BASE + 4'(rpw_pkg::LIM_COUNT)) begin
                  rdata_q <= 8'(limit_q[addr - rpw_pkg::ADDR_LIMIT_BASE]);
               end else begin
                  rdata_q <= 8'h00;
               end
            end
         endcase
      end
   end

   assign rdata = rdata_q;
   assign guide_detect_event = guide_ev_q;
   assign error_event = err_ev_q;
   assign end_of_frame_event = end_ev_q;
   assign byte_full_event = full_ev_q;
endmodule

// ### verilog/rpw_pkg.sv
// Package of constants for the remote pulse-width receiver.
package rpw_pkg;
   // Register indexes on the byte address port.
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_STATUS_CLEAR = 4'h2;
   localparam logic [3:0] ADDR_DATA_BUFFER = 4'h3;
   localparam logic [3:0] ADDR_SHIFT_REG = 4'h4;
   localparam logic [3:0] ADDR_SHIFT_COUNT = 4'h5;
   localparam logic [3:0] ADDR_LIMIT_BASE = 4'h6;
   // Limit order starting at the limit base.
   localparam int LIM_GUIDE_SHORT = 0;
   localparam int LIM_GUIDE_LONG = 1;
   localparam int LIM_LOW_SHORT = 2;
   localparam int LIM_LOW_LONG = 3;
   localparam int LIM_ZERO_SHORT = 4;
   localparam int LIM_ZERO_LONG = 5;
   localparam int LIM_ONE_SHORT = 6;
   localparam int LIM_ONE_LONG = 7;
   localparam int LIM_END_WIDTH = 8;
   localparam int LIM_COUNT = 9;
   // Control register fields and reset value.
   localparam int CTL_ENABLE = 7;
   localparam int CTL_NOISE_WIDTH = 6;
   localparam int CTL_PRESCALE = 5;
   localparam int CTL_INVERT = 4;
   localparam int CTL_SEL_HI = 1;
   localparam int CTL_SEL_LO = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'hf3;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // Status bit positions.
   localparam int ST_ERROR = 0;
   localparam int ST_GUIDE = 1;
   localparam int ST_END = 2;
   localparam int ST_FULL = 3;
   // Source divider terminal masks.
   localparam logic [7:0] DIV64_MASK = 8'h3f;
   localparam logic [7:0] DIV128_MASK = 8'h7f;
   localparam logic [7:0] DIV256_MASK = 8'hff;
   // Measurement states.
   typedef enum logic [2:0] {
      WAIT_RISE = 3'b000,
      GUIDE_HIGH = 3'b001,
      DATA_LOW = 3'b010,
      DATA_HIGH = 3'b011,
      END_WIDTH = 3'b100,
      HALTED = 3'b101
   } rx_state_t;
endpackage
